// >>> hw/qcs_map.svh
// register offsets, field positions, reset values for the quad pin decoder
`ifndef QCS_MAP_SVH
`define QCS_MAP_SVH

// special function register offsets
`define QCS_OFS_CONF_LO   8'hc2
`define QCS_OFS_CONF_HI   8'hc3
`define QCS_OFS_BASE0_LO  8'h84
`define QCS_OFS_BASE0_HI  8'h85
`define QCS_OFS_BASE1_LO  8'h94
`define QCS_OFS_BASE1_HI  8'h95
`define QCS_OFS_BASE2_LO  8'hac
`define QCS_OFS_BASE2_HI  8'had
`define QCS_OFS_BASE3_LO  8'hb4
`define QCS_OFS_BASE3_HI  8'hb5
`define QCS_OFS_POLARITY  8'hae
`define QCS_OFS_DATA      8'hd8

// field positions inside a configuration byte (upper pin of the pair)
`define QCS_FUN_HI_MSB    7
`define QCS_FUN_HI_LSB    6
`define QCS_CMP_HI_MSB    5
`define QCS_CMP_HI_LSB    4
// lower pin of the pair
`define QCS_FUN_LO_MSB    3
`define QCS_FUN_LO_LSB    2
`define QCS_CMP_LO_MSB    1
`define QCS_CMP_LO_LSB    0
// polarity bits: pin n sits at bit n + 4
`define QCS_POL_LSB       4

// reset values
`define QCS_RST_CONF      8'h00
`define QCS_RST_BASE      8'h00
`define QCS_RST_POLARITY  4'h0
`define QCS_RST_DATA      4'hf

`endif

// >>> hw/qcs_pkg.sv
// types shared by the quad pin chip select decoder
package qcs_pkg;

  // pin function field
  typedef enum logic [1:0] {
    QCS_FUN_GPIO   = 2'h0,
    QCS_FUN_RD     = 2'h1,
    QCS_FUN_WR     = 2'h2,
    QCS_FUN_RDWR   = 2'h3
  } qcs_fun_t;

  // comparison length field
  typedef enum logic [1:0] {
    QCS_CMP_FULL   = 2'h0,
    QCS_CMP_A15_1  = 2'h1,
    QCS_CMP_A15_2  = 2'h2,
    QCS_CMP_A15_8  = 2'h3
  } qcs_cmp_t;

  // one pin's decode setup
  typedef struct packed {
    qcs_fun_t    fun;
    qcs_cmp_t    cmp;
    logic [15:0] base;
    logic        active_high;
  } qcs_pin_cfg_t;

  // external data memory cycle from the core
  typedef struct packed {
    logic [15:0] addr;
    logic        rd;
    logic        wr;
  } qcs_ext_cycle_t;

  // special function register access from the core
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       we;
    logic       re;
  } qcs_sfr_req_t;

endpackage : qcs_pkg

// >>> hw/qcs_addr_match.sv
// one pin's address comparator and strobe qualifier
`timescale 1ns/100ps
module qcs_addr_match
  import qcs_pkg::*;
(
  input  wire qcs_pin_cfg_t   cfg,
  input  wire qcs_ext_cycle_t cyc,
  output logic                hit,
  output logic                strobe
);

  // mask of address bits that take part in the compare
  function automatic logic [15:0] cmp_mask(input qcs_cmp_t c);
    case (c)
      QCS_CMP_FULL:  cmp_mask = 16'hffff;
      QCS_CMP_A15_1: cmp_mask = 16'hfffe;
      QCS_CMP_A15_2: cmp_mask = 16'hfffc;
      QCS_CMP_A15_8: cmp_mask = 16'hff00;
      default:       cmp_mask = 16'hffff;
    endcase
  endfunction : cmp_mask

  // base and length together give the window
  always_comb begin
    hit = ((cyc.addr ^ cfg.base) & cmp_mask(cfg.cmp)) == 16'h0000;
  end

  // qualify by access direction, idle otherwise
  always_comb begin
    case (cfg.fun)
      QCS_FUN_RD:   strobe = hit & cyc.rd;
      QCS_FUN_WR:   strobe = hit & cyc.wr;
      QCS_FUN_RDWR: strobe = hit & (cyc.rd | cyc.wr);
      default:      strobe = 1'b0;
    endcase
  end

endmodule : qcs_addr_match

// >>> hw/qcs_pin_sync.sv
// three stage synchroniser with agreement filter for the port pins
`timescale 1ns/100ps
module qcs_pin_sync (
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic [3:0] pin_in,
  output logic      [3:0] pin_level
);

  logic [3:0] s1_q;   // first stage, read only by s2
  logic [3:0] s2_q;   // second stage
  logic [3:0] s3_q;   // third stage
  logic [3:0] lvl_q;  // accepted level

  // shift chain
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s1_q <= 4'hf;
      s2_q <= 4'hf;
      s3_q <= 4'hf;
    end else begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // take a bit once stages two and three agree
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      lvl_q <= 4'hf;
    end else begin
      lvl_q <= (s2_q & ~(s2_q ^ s3_q)) | (lvl_q & (s2_q ^ s3_q));
    end
  end

  assign pin_level = lvl_q;

endmodule : qcs_pin_sync

// >>> hw/qcs_top.sv
// quad pin port with per pin chip select strobe decode
// notes
// strobe pins registered: one clock behind core strobe
// strobe pins always driven, idle at inverse polarity
// reset polarity zero: strobes active low, idle high
// port bits only pull low, ones left to the pull-up
// port reads give filtered pin levels, not data bits
// pin read path lags a pin change by about five clocks
// unused offsets read zero and drop writes
// polarity low nibble and data high nibble read zero
// base bytes land singly: window moves in two steps
// park a pin in function 00 while re-aiming its window
// read data registered, one clock after the read pulse
// sfr_hit claims our offsets for the core read mux
`timescale 1ns/100ps
`include "qcs_map.svh"
module qcs_top
  import qcs_pkg::*;
(
  input  wire logic           clk_sys,
  input  wire logic           rst,
  input  wire qcs_sfr_req_t   sfr_req,
  output logic                sfr_hit,
  output logic         [7:0]  sfr_rdata,
  input  wire qcs_ext_cycle_t ext_cyc,
  input  wire logic    [3:0]  pin_in,
  output logic         [3:0]  pin_out,
  output logic         [3:0]  pin_oe
);

  // configuration and data registers
  logic [7:0]  conf_lo_q;       // pins one and zero setup
  logic [7:0]  conf_hi_q;       // pins three and two setup
  logic [7:0]  base_lo_q [4];   // low base byte per pin
  logic [7:0]  base_hi_q [4];   // high base byte per pin
  logic [3:0]  polarity_q;      // one per pin, set = active high
  logic [3:0]  data_q;          // port data bits
  logic [7:0]  rdata_q;         // read data register
  logic [3:0]  out_q;           // pin output level
  logic [3:0]  oe_q;            // pin output enable
  logic [3:0]  out_d;           // next pin output level
  logic [3:0]  oe_d;            // next pin output enable

  // decoded per pin setup
  qcs_pin_cfg_t cfg [4];
  logic [3:0]   strobe;         // qualified strobe per pin
  logic [3:0]   pin_level;      // filtered pin inputs

  // write and read decode
  logic        wr_conf_lo;
  logic        wr_conf_hi;
  logic        wr_pol;
  logic        wr_data;
  logic [3:0]  wr_base_lo;
  logic [3:0]  wr_base_hi;
  logic [7:0]  rd_mux;          // selected read value
  logic        mapped;          // offset belongs to this block

  // offset table for the base byte registers
  function automatic logic [7:0] base_lo_ofs(input int unsigned n);
    case (n)
      0:       base_lo_ofs = `QCS_OFS_BASE0_LO;
      1:       base_lo_ofs = `QCS_OFS_BASE1_LO;
      2:       base_lo_ofs = `QCS_OFS_BASE2_LO;
      default: base_lo_ofs = `QCS_OFS_BASE3_LO;
    endcase
  endfunction : base_lo_ofs

  function automatic logic [7:0] base_hi_ofs(input int unsigned n);
    case (n)
      0:       base_hi_ofs = `QCS_OFS_BASE0_HI;
      1:       base_hi_ofs = `QCS_OFS_BASE1_HI;
      2:       base_hi_ofs = `QCS_OFS_BASE2_HI;
      default: base_hi_ofs = `QCS_OFS_BASE3_HI;
    endcase
  endfunction : base_hi_ofs

  // one two bit field out of a configuration byte
  function automatic logic [1:0] field2(input logic [7:0]  b,
                                        input int unsigned lsb);
    field2 = b[lsb +: 2];
  endfunction : field2

  // strobe pin level: polarity set gives active high
  function automatic logic strobe_level(input logic fire,
                                        input logic active_high);
    strobe_level = fire ~^ active_high;
  endfunction : strobe_level

  // write strobes per register
  always_comb begin
    // one decode per register
    wr_conf_lo = sfr_req.we & (sfr_req.addr == `QCS_OFS_CONF_LO);
    wr_conf_hi = sfr_req.we & (sfr_req.addr == `QCS_OFS_CONF_HI);
    wr_pol     = sfr_req.we & (sfr_req.addr == `QCS_OFS_POLARITY);
    wr_data    = sfr_req.we & (sfr_req.addr == `QCS_OFS_DATA);
    // base bytes, one pair per pin
    for (int n = 0; n < 4; n++) begin
      wr_base_lo[n] = sfr_req.we & (sfr_req.addr == base_lo_ofs(n));
      wr_base_hi[n] = sfr_req.we & (sfr_req.addr == base_hi_ofs(n));
    end
  end

  // configuration bytes
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      conf_lo_q <= `QCS_RST_CONF;
      conf_hi_q <= `QCS_RST_CONF;
    end else begin
      // pins one and zero
      if (wr_conf_lo) begin
        conf_lo_q <= sfr_req.wdata;
      end
      // pins three and two
      if (wr_conf_hi) begin
        conf_hi_q <= sfr_req.wdata;
      end
    end
  end

  // base address bytes, two per pin
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      // all windows start at zero
      for (int n = 0; n < 4; n++) begin
        base_lo_q[n] <= `QCS_RST_BASE;
        base_hi_q[n] <= `QCS_RST_BASE;
      end
    end else begin
      // one byte per write, the other kept
      for (int n = 0; n < 4; n++) begin
        if (wr_base_lo[n]) begin
          base_lo_q[n] <= sfr_req.wdata;
        end
        if (wr_base_hi[n]) begin
          base_hi_q[n] <= sfr_req.wdata;
        end
      end
    end
  end

  // polarity byte, only the upper nibble is kept
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      // strobes come out of reset active low
      polarity_q <= `QCS_RST_POLARITY;
    end else if (wr_pol) begin
      polarity_q <= sfr_req.wdata[`QCS_POL_LSB +: 4];
    end
  end

  // port data, low nibble only
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      // ones: pins released to pull-ups
      data_q <= `QCS_RST_DATA;
    end else if (wr_data) begin
      data_q <= sfr_req.wdata[3:0];
    end
  end

  // unpack the configuration bytes into per pin setup
  always_comb begin
    // upper byte: pins three and two
    cfg[3].fun = qcs_fun_t'(field2(conf_hi_q, `QCS_FUN_HI_LSB));
    cfg[3].cmp = qcs_cmp_t'(field2(conf_hi_q, `QCS_CMP_HI_LSB));
    cfg[2].fun = qcs_fun_t'(field2(conf_hi_q, `QCS_FUN_LO_LSB));
    cfg[2].cmp = qcs_cmp_t'(field2(conf_hi_q, `QCS_CMP_LO_LSB));
    // lower byte: pins one and zero
    cfg[1].fun = qcs_fun_t'(field2(conf_lo_q, `QCS_FUN_HI_LSB));
    cfg[1].cmp = qcs_cmp_t'(field2(conf_lo_q, `QCS_CMP_HI_LSB));
    cfg[0].fun = qcs_fun_t'(field2(conf_lo_q, `QCS_FUN_LO_LSB));
    cfg[0].cmp = qcs_cmp_t'(field2(conf_lo_q, `QCS_CMP_LO_LSB));
    // base and polarity per pin
    for (int n = 0; n < 4; n++) begin
      cfg[n].base        = {base_hi_q[n], base_lo_q[n]};
      cfg[n].active_high = polarity_q[n];
    end
  end

  // one comparator per pin
  for (genvar g = 0; g < 4; g++) begin : g_match
    qcs_addr_match u_match (
      .cfg    (cfg[g]),
      .cyc    (ext_cyc),
      // bare match unused: the strobe already carries it
      .hit    (),
      .strobe (strobe[g])
    );
  end

  // filtered copy of the pins for port reads
  qcs_pin_sync u_sync (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .pin_in    (pin_in),
    .pin_level (pin_level)
  );

  // next pin drive: port bit or strobe level per pin
  always_comb begin
    // default: released, no drive
    out_d = 4'h0;
    oe_d  = 4'h0;
    for (int n = 0; n < 4; n++) begin
      case (cfg[n].fun)
        // quasi-bidirectional: strong low, weak high left to pull-up
        QCS_FUN_GPIO: begin
          out_d[n] = 1'b0;
          oe_d[n]  = ~data_q[n];
        end
        // strobe modes: always driven, inactive level between hits
        default: begin
          out_d[n] = strobe_level(strobe[n],
                                  cfg[n].active_high);
          oe_d[n]  = 1'b1;
        end
      endcase
    end
  end

  // pin drivers, registered; lag the core strobe by one cycle
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      // all pins released to their pull-ups
      out_q <= 4'h0;
      oe_q  <= 4'h0;
    end else begin
      out_q <= out_d;
      oe_q  <= oe_d;
    end
  end

  // registered drive straight to the pads
  assign pin_out = out_q;
  assign pin_oe  = oe_q;

  // read value selection, reserved bits read zero
  always_comb begin
    // reserved bits and unmapped offsets read zero
    rd_mux = 8'h00;
    mapped = 1'b1;
    case (sfr_req.addr)
      `QCS_OFS_CONF_LO:  rd_mux = conf_lo_q;
      `QCS_OFS_CONF_HI:  rd_mux = conf_hi_q;
      `QCS_OFS_POLARITY: rd_mux = {polarity_q, 4'h0};
      `QCS_OFS_DATA:     rd_mux = {4'h0, pin_level};
      default: begin
        // base bytes sit at scattered offsets
        mapped = 1'b0;
        for (int n = 0; n < 4; n++) begin
          // low then high byte of pin n
          if (sfr_req.addr == base_lo_ofs(n)) begin
            rd_mux = base_lo_q[n];
            mapped = 1'b1;
          end
          if (sfr_req.addr == base_hi_ofs(n)) begin
            rd_mux = base_hi_q[n];
            mapped = 1'b1;
          end
        end
      end
    endcase
  end

  // read data register, loaded on a read request
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      // cleared with the core
      rdata_q <= 8'h00;
    end else if (sfr_req.re) begin
      // unmapped offsets answer zero
      rdata_q <= mapped ? rd_mux : 8'h00;
    end
  end

  // read data and offset claim to the core
  assign sfr_rdata = rdata_q;
  assign sfr_hit   = mapped;

endmodule : qcs_top

// >>> bench/qcs_top_sva.sv
// port checker for the quad pin decoder, pin 0 shadowed
`timescale 1ns/100ps
module qcs_top_sva
  import qcs_pkg::*;
(
  input wire logic           clk_sys,
  input wire logic           rst,
  input wire qcs_sfr_req_t   sfr_req,
  input wire logic           sfr_hit,
  input wire logic     [7:0] sfr_rdata,
  input wire qcs_ext_cycle_t ext_cyc,
  input wire logic     [3:0] pin_in,
  input wire logic     [3:0] pin_out,
  input wire logic     [3:0] pin_oe
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic [3:0]  conf_q; // pin 0 function and length
  logic [15:0] base_q; // pin 0 base address
  logic        pol_q;  // pin 0 strobe polarity
  logic        dat_q;  // pin 0 data bit
  logic [15:0] mask;   // compared address bits
  logic        hit;    // address inside window
  logic        act;    // strobe due this cycle
  // shadow pin 0 setup from register writes
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      conf_q <= 4'h0;
      base_q <= 16'h0000;
      pol_q  <= 1'b0;
      dat_q  <= 1'b1;
    end else if (sfr_req.we) begin
      case (sfr_req.addr)
        8'hc2: conf_q <= sfr_req.wdata[3:0];
        8'h84: base_q[7:0] <= sfr_req.wdata;
        8'h85: base_q[15:8] <= sfr_req.wdata;
        8'hae: pol_q <= sfr_req.wdata[4];
        8'hd8: dat_q <= sfr_req.wdata[0];
        default: ;
      endcase
    end
  end
  // window mask from the length field
  always_comb begin
    case (conf_q[1:0])
      2'h0: mask = 16'hffff;
      2'h1: mask = 16'hfffe;
      2'h2: mask = 16'hfffc;
      default: mask = 16'hff00;
    endcase
  end
  assign hit = ((ext_cyc.addr ^ base_q) & mask) == 16'h0000;
  assign act = hit && ((ext_cyc.rd && conf_q[2]) || (ext_cyc.wr && conf_q[3]));
  reset_idle_a:
    assert property (disable iff (1'b0) rst |=> pin_oe == 4'h0)
    else $error("pins driven after reset");
  gpio_drive_a:
    assert property (conf_q[3:2] == 2'h0 |=>
                     !pin_out[0] && pin_oe[0] == !$past(dat_q))
    else $error("port bit drive wrong");
  rd_strobe_a:
    assert property (conf_q[3:2] == 2'h1 && hit && ext_cyc.rd |=>
                     pin_out[0] == $past(pol_q) && pin_oe[0])
    else $error("read strobe missing");
  wr_strobe_a:
    assert property (conf_q[3:2] == 2'h2 && hit && ext_cyc.wr |=>
                     pin_out[0] == $past(pol_q))
    else $error("write strobe missing");
  both_strobe_a:
    assert property (conf_q[3:2] == 2'h3 && hit &&
                     (ext_cyc.rd || ext_cyc.wr) |=>
                     pin_out[0] == $past(pol_q))
    else $error("read write strobe missing");
  idle_level_a:
    assert property (conf_q[3:2] != 2'h0 && !act |=>
                     pin_out[0] != $past(pol_q) && pin_oe[0])
    else $error("strobe active without match");
  conf_lo_rb_a:
    assert property (sfr_req.we && sfr_req.addr == 8'hc2 ##2
                     sfr_req.re && sfr_req.addr == 8'hc2 |=>
                     sfr_rdata == $past(sfr_req.wdata, 3))
    else $error("lower config readback wrong");
  conf_hi_rb_a:
    assert property (sfr_req.we && sfr_req.addr == 8'hc3 ##2
                     sfr_req.re && sfr_req.addr == 8'hc3 |=>
                     sfr_rdata == $past(sfr_req.wdata, 3))
    else $error("upper config readback wrong");
  unmapped_read_a:
    assert property (sfr_req.re && !sfr_hit |=> sfr_rdata == 8'h00)
    else $error("unmapped read not zero");
  cover property (conf_q[3:2] == 2'h1 && act);
  cover property (conf_q[3:2] == 2'h2 && act);
  cover property (sfr_req.re && !sfr_hit);
endmodule : qcs_top_sva
bind qcs_top qcs_top_sva u_sva (.clk_sys(clk_sys), .rst(rst),
  .sfr_req(sfr_req), .sfr_hit(sfr_hit), .sfr_rdata(sfr_rdata),
  .ext_cyc(ext_cyc), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe));

// >>> bench/qcs_periph.sv
// far side of the port: pull-ups behind every pin
`timescale 1ns/100ps
module qcs_periph (
  input  wire logic [3:0] pin_out,
  input  wire logic [3:0] pin_oe,
  output logic      [3:0] pin_in
);
  // released pins float up, driven ones follow the drive
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      pin_in[i] = pin_oe[i] ? pin_out[i] : 1'b1;
    end
  end
endmodule : qcs_periph

// >>> bench/qcs_top_bench.sv
// self-checking bench for the quad pin decoder
`timescale 1ns/100ps
module qcs_top_bench
  import qcs_pkg::*;
;
  logic           clk_sys;   // core clock
  logic           rst;       // sync reset
  qcs_sfr_req_t   sfr_req;   // register access
  logic           sfr_hit;   // offset decoded
  logic     [7:0] sfr_rdata; // read data
  qcs_ext_cycle_t ext_cyc;   // external data cycle
  logic     [3:0] pin_in;    // resolved pin level
  logic     [3:0] pin_out;   // pin drive
  logic     [3:0] pin_oe;    // pin enable
  int             error_cnt; // mismatches
  int             n_checks;  // comparisons
  int             cycles;    // hang guard
  logic     [7:0] rd;        // read result
  logic    [15:0] flip [5] = '{16'h0000, 16'h0001, 16'h0002, 16'h0080,
                               16'h0100}; // address offsets from base
  qcs_top DUT (.clk_sys(clk_sys), .rst(rst), .sfr_req(sfr_req),
    .sfr_hit(sfr_hit), .sfr_rdata(sfr_rdata), .ext_cyc(ext_cyc),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe));
  qcs_periph u_periph (.pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
    sfr_req <= '{a, d, 1'b1, 1'b0};
    @(posedge clk_sys);
    sfr_req.we <= 1'b0;
    @(posedge clk_sys);
  endtask : sfr_wr
  task automatic sfr_rd(input logic [7:0] a, output logic [7:0] d);
    sfr_req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk_sys);
    sfr_req.re <= 1'b0;
    @(posedge clk_sys);
    d = sfr_rdata;
  endtask : sfr_rd
  function automatic logic [15:0] win(input logic [1:0] c);
    case (c)
      2'h0: win = 16'hffff;
      2'h1: win = 16'hfffe;
      2'h2: win = 16'hfffc;
      default: win = 16'hff00;
    endcase
  endfunction : win
  // reset values, readback, reserved bits, unmapped offset
  task automatic test_regs();
    sfr_rd(8'hc3, rd);
    check(rd, 8'h00);
    sfr_wr(8'hc2, 8'h5a);
    sfr_rd(8'hc2, rd);
    check(rd, 8'h5a);
    sfr_wr(8'hc3, 8'ha5);
    sfr_rd(8'hc3, rd);
    check(rd, 8'ha5);
    sfr_wr(8'h85, 8'h12);
    sfr_rd(8'h85, rd);
    check(rd, 8'h12);
    check({7'h00, sfr_hit}, 8'h01);
    sfr_wr(8'hae, 8'hff);
    sfr_rd(8'hae, rd);
    check(rd, 8'hf0);
    sfr_rd(8'h00, rd);
    check(rd, 8'h00);
    check({7'h00, sfr_hit}, 8'h00);
    $display("test regs done");
  endtask : test_regs
  // every strobe mode, length and polarity on pins 0 and 3
  task automatic test_strobes();
    logic e;
    sfr_wr(8'h84, 8'h34);
    sfr_wr(8'h85, 8'h12);
    sfr_wr(8'hb4, 8'h34);
    sfr_wr(8'hb5, 8'h12);
    for (int f = 1; f < 4; f++) begin
      for (int c = 0; c < 4; c++) begin
        for (int p = 0; p < 2; p++) begin
          sfr_wr(8'hc2, {4'h0, f[1:0], c[1:0]});
          sfr_wr(8'hc3, {f[1:0], c[1:0], 4'h0});
          sfr_wr(8'hae, {p[0], 2'b00, p[0], 4'h0});
          for (int k = 0; k < 10; k++) begin
            e = (((flip[k / 2] & win(c[1:0])) == 16'h0000)
                 && (k[0] ? f[1] : f[0])) ~^ p[0];
            ext_cyc <= '{16'h1234 ^ flip[k / 2], ~k[0], k[0]};
            @(posedge clk_sys);
            ext_cyc <= '{16'h1234, 1'b0, 1'b0};
            @(negedge clk_sys);
            check({4'h0, pin_out}, {4'h0, e, 2'b00, e});
            check({4'h0, pin_oe}, 8'h09);
            @(posedge clk_sys);
            @(negedge clk_sys);
            check({4'h0, pin_out}, {4'h0, ~p[0], 2'b00, ~p[0]});
            @(posedge clk_sys);
          end
        end
      end
    end
    $display("test strobes done");
  endtask : test_strobes
  // pins 1 and 2 as read/write strobes on a page, active high
  task automatic test_mid_pins();
    sfr_wr(8'h94, 8'h00);
    sfr_wr(8'h95, 8'h56);
    sfr_wr(8'hac, 8'h00);
    sfr_wr(8'had, 8'h56);
    sfr_wr(8'hc2, 8'hf0);
    sfr_wr(8'hc3, 8'h0f);
    sfr_wr(8'hae, 8'h60);
    ext_cyc <= '{16'h56ab, 1'b0, 1'b1};
    @(posedge clk_sys);
    ext_cyc <= '{16'h57ab, 1'b1, 1'b0};
    @(negedge clk_sys);
    check({4'h0, pin_out}, 8'h06);
    check({4'h0, pin_oe}, 8'h06);
    @(posedge clk_sys);
    ext_cyc <= '{16'h0000, 1'b0, 1'b0};
    @(negedge clk_sys);
    check({4'h0, pin_out}, 8'h00);
    @(posedge clk_sys);
    $display("test mid pins done");
  endtask : test_mid_pins
  // port bits driven open drain, read back through pull-ups
  task automatic test_gpio();
    sfr_wr(8'hc2, 8'h00);
    sfr_wr(8'hc3, 8'h00);
    sfr_wr(8'hd8, 8'h05);
    repeat (8) @(posedge clk_sys);
    check({4'h0, pin_oe}, 8'h0a);
    check({4'h0, pin_out}, 8'h00);
    sfr_rd(8'hd8, rd);
    check(rd, 8'h05);
    $display("test gpio done");
  endtask : test_gpio
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : give_verdict
  // free running clock
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  // hang guard
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      error_cnt++;
      give_verdict();
    end
  end
  // main sequence
  initial begin
    rst = 1'b1;
    sfr_req = '0;
    ext_cyc = '0;
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    test_regs();
    test_strobes();
    test_mid_pins();
    test_gpio();
    give_verdict();
  end
endmodule : qcs_top_bench
